// File: tcmc_pkg.sv
package tcmc_pkg;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] TCMC_OFS_CH12 = 8'h18; // Channel 1/2 control
    localparam logic [7:0] TCMC_OFS_CH34 = 8'h1c; // Channel 3/4 control
    localparam logic [7:0] TCMC_OFS_ENA = 8'h20; // Channel enables
    localparam logic [7:0] TCMC_OFS_TRG = 8'h24; // Trigger source select
    localparam logic [7:0] TCMC_OFS_STAT = 8'h28; // Read-only status

    // ----------------------------------------
    // Reset values and field positions
    // ----------------------------------------
    localparam logic [15:0] TCMC_CTRL_RST = 16'h0000;
    localparam logic [2:0] TCMC_TRG_RST = 3'h0;
    localparam int TCMC_ENA_STRIDE = 4; // Enable bit every 4th bit
    localparam int TCMC_TRG_EXT_BIT = 2; // Set: external trigger input
    localparam int TCMC_SEL_LSB = 0; // Direction/source select
    localparam int TCMC_PSC_LSB = 2; // Capture divider
    localparam int TCMC_FLT_LSB = 4; // Input filter code
    localparam int TCMC_FAST_BIT = 2; // Compare quick response
    localparam int TCMC_PRE_BIT = 3; // Compare shadow enable
    localparam int TCMC_MODE_LSB = 4; // Compare behaviour
    localparam int TCMC_CLR_BIT = 7; // Compare clear on external

    // ----------------------------------------
    // Direction select codes
    // ----------------------------------------
    localparam logic [1:0] TCMC_SEL_OUT = 2'h0;
    localparam logic [1:0] TCMC_SEL_OWN = 2'h1;
    localparam logic [1:0] TCMC_SEL_NBR = 2'h2;
    localparam logic [1:0] TCMC_SEL_TRG = 2'h3;

    // Sample rate: index n samples once per 2**n clocks
    localparam int TCMC_DIV_W = 5;

    // Output compare controls of one channel
    typedef struct packed {
        logic clear_on_ext;
        logic [2:0] compare_behaviour;
        logic shadow_on;
        logic quick_response;
    } tcmc_oc_t;

    // Filter setting: rate index and event count
    typedef struct packed {
        logic bypass;
        logic [2:0] rate;
        logic [3:0] events;
    } tcmc_flt_t;

endpackage : tcmc_pkg

// File: tcmc_timer_channel.sv
// Notes on behaviour
// - Codes 0100-0111: half/quarter rate, 6/8 events
// - Codes 1100-1111: /16 N8, /32 N5,6,8
// - Divider captures every 1,2,4,8 events
// - Divider counter cleared while channel disabled
// - Select: output, own, neighbour, trigger input
// - Trigger capture only with internal trigger
// - Select field writable only while disabled
// - Byte means compare or capture per direction
// - Ch4 compare fields at 15,14:12,11,10,9:8
// - Ch3 compare fields at 7,6:4,3,2,1:0
// - Ch4 capture fields 15:12, 11:10, 9:8
// - Ch3 capture fields 7:4, 3:2, 1:0
// - Ch1 capture fields 7:4, 3:2, 1:0
// - Ch2 divider 11:10, select 9:8
// - Filter flips after N equal new samples
// - 0000 bypass, 0001 N2, 1000 /8 N6
module tcmc_timer_channel
    import tcmc_pkg::*;
#(
    parameter int NCH = 4
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [NCH-1:0] timer_input,
    input wire logic internal_trigger_source,
    output tcmc_oc_t [NCH-1:0] oc_config,
    output logic [NCH-1:0] channel_is_input,
    output logic [NCH-1:0] capture_pulse,
    output logic [NCH-1:0] filtered_level
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // Filter table
    // ----------------------------------------
    // Maps a four bit code to bypass, rate index and event count.
    // Rate index n means one sample every 2**n kernel clocks.
    // The sampling clock equals the kernel clock in this block,
    // so there is no extra dead-time division.
    // Codes 1010 and 1011 reuse the sixteenth rate, with five and
    // six events, to keep the table monotonic in its filter length.
    function automatic tcmc_flt_t flt_decode(input logic [3:0] code);
        tcmc_flt_t f;
        f = '{bypass: 1'b0, rate: 3'h0, events: 4'h8};
        unique case (code)
            4'h0: f.bypass = 1'b1;
            4'h1: f.events = 4'h2;
            4'h2: f.events = 4'h4;
            4'h3: f.events = 4'h8;
            4'h4: f = '{1'b0, 3'h1, 4'h6};
            4'h5: f = '{1'b0, 3'h1, 4'h8};
            4'h6: f = '{1'b0, 3'h2, 4'h6};
            4'h7: f = '{1'b0, 3'h2, 4'h8};
            4'h8: f = '{1'b0, 3'h3, 4'h6};
            4'h9: f = '{1'b0, 3'h3, 4'h8};
            4'ha: f = '{1'b0, 3'h4, 4'h5};
            4'hb: f = '{1'b0, 3'h4, 4'h6};
            4'hc: f = '{1'b0, 3'h4, 4'h8};
            4'hd: f = '{1'b0, 3'h5, 4'h5};
            4'he: f = '{1'b0, 3'h5, 4'h6};
            4'hf: f = '{1'b0, 3'h5, 4'h8};
        endcase
        return f;
    endfunction : flt_decode

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    // One wait state on every access keeps the read path registered:
    // the first cycle loads read data, the second hands it over.
    // Writes land in the second cycle only, so a master that drops
    // its request early changes nothing.
    logic ack_reg; // Second cycle of an access
    logic [31:0] rdata_reg; // Read data held for the master
    logic [15:0] ctrl_reg [2]; // Channel 1/2 and 3/4 control
    logic [15:0] ctrl_next [2];
    logic [NCH-1:0] ena_reg; // Channel enables
    logic [2:0] trg_reg; // Trigger source select
    logic [31:0] rd_mux; // Read selection
    wire hit_ch12 = avs_address == TCMC_OFS_CH12;
    wire hit_ch34 = avs_address == TCMC_OFS_CH34;
    wire hit_ena = avs_address == TCMC_OFS_ENA;
    wire hit_trg = avs_address == TCMC_OFS_TRG;
    wire hit_stat = avs_address == TCMC_OFS_STAT;
    // A write lands on the edge where waitrequest is low
    wire wr_go = avs_write & ack_reg;
    wire [15:0] wr_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Every access waits exactly one cycle
    // Back to back is fine: ack_reg falls on the accepting edge
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign avs_readdata = rdata_reg;

    // Enable bits sit at 0, 4, 8, 12
    logic [15:0] ena_word;
    logic [NCH-1:0] ena_wr;
    always_comb begin
        ena_word = 16'h0000;
        for (int c = 0; c < NCH; c++) begin
            ena_word[c*TCMC_ENA_STRIDE] = ena_reg[c];
            ena_wr[c] = avs_writedata[c*TCMC_ENA_STRIDE];
        end
    end

    // Unmapped addresses read as zero
    // Status word: directions in the high nibble, levels in the low
    assign rd_mux = hit_ch12 ? {16'h0000, ctrl_reg[0]} :
                    hit_ch34 ? {16'h0000, ctrl_reg[1]} :
                    hit_ena ? {16'h0000, ena_word} :
                    hit_trg ? {29'h0, trg_reg} :
                    hit_stat ? {24'h0, channel_is_input, filtered_level} :
                    32'h0;

    // Control write merge with lane and direction locks
    // A locked select field keeps its value while the other bits of
    // the same byte still take the write, so software may retune the
    // filter of a running channel without stopping it.
    always_comb begin
        for (int r = 0; r < 2; r++) begin
            ctrl_next[r] = ctrl_reg[r];
            if (wr_go && (r == 0 ? hit_ch12 : hit_ch34)) begin
                ctrl_next[r] = (ctrl_reg[r] & ~wr_mask) |
                               (avs_writedata[15:0] & wr_mask);
                // Keep the select field of an enabled channel
                for (int h = 0; h < 2; h++) begin
                    if (ena_reg[2*r+h]) begin
                        ctrl_next[r][8*h +: 2] = ctrl_reg[r][8*h +: 2];
                    end
                end
            end
        end
    end

    // Bus state and register storage
    // Lanes 2 and 3 carry nothing and are ignored
    // Status is read only: a write to it falls through
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0;
            ctrl_reg[0] <= TCMC_CTRL_RST;
            ctrl_reg[1] <= TCMC_CTRL_RST;
            ena_reg <= '0;
            trg_reg <= TCMC_TRG_RST;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
            if (avs_read && !ack_reg) begin
                rdata_reg <= rd_mux;
            end
            ctrl_reg[0] <= ctrl_next[0];
            ctrl_reg[1] <= ctrl_next[1];
            if (wr_go && hit_ena && avs_byteenable[0]) begin
                ena_reg[1:0] <= ena_wr[1:0];
            end
            if (wr_go && hit_ena && avs_byteenable[1]) begin
                ena_reg[NCH-1:2] <= ena_wr[NCH-1:2];
            end
            if (wr_go && hit_trg && avs_byteenable[0]) begin
                trg_reg <= avs_writedata[2:0];
            end
        end
    end

    // ----------------------------------------
    // Input synchroniser and sample clock
    // ----------------------------------------
    // Pins are asynchronous: two flops before any filter reads them.
    // The divider is never cleared by software, so the phase of the
    // slow sample strobes is fixed only by reset; a filter change can
    // land anywhere inside a sample period.
    logic [NCH-1:0] meta_reg; // First stage, read only by sync_reg
    logic [NCH-1:0] sync_reg; // Safe copy of the pins
    logic [TCMC_DIV_W-1:0] div_reg; // Free running sample divider
    logic [5:0] tick; // Sample strobes per rate index
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
            div_reg <= '0;
        end else begin
            meta_reg <= timer_input;
            sync_reg <= meta_reg;
            div_reg <= div_reg + 1'b1;
        end
    end
    // Rate n strobes once every 2**n clocks
    // Index 0 is every clock, index 5 every 32 clocks
    assign tick = {&div_reg[4:0], &div_reg[3:0], &div_reg[2:0],
                   &div_reg[1:0], div_reg[0], 1'b1};

    // Trigger capture needs an internal trigger selection
    // Select bit 2 set means an external trigger input
    wire trg_ok = ~trg_reg[TCMC_TRG_EXT_BIT];

    // ----------------------------------------
    // Per channel logic
    // ----------------------------------------
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            // Each channel owns one byte of a control register:
            // channels 1 and 3 the low byte, 2 and 4 the high byte.
            // The filter runs in both directions, so an output channel
            // can still feed its paired input channel.
            // Byte of this channel in its control register
            wire [7:0] cfg = ctrl_reg[c/2][8*(c%2) +: 8];
            wire [1:0] sel = cfg[TCMC_SEL_LSB +: 2];
            wire [1:0] psc = cfg[TCMC_PSC_LSB +: 2];
            wire tcmc_flt_t flt = flt_decode(cfg[TCMC_FLT_LSB +: 4]);
            wire is_in = sel != TCMC_SEL_OUT;
            logic [2:0] run_reg; // Consecutive new-level samples
            logic lvl_reg; // Filtered level
            logic src_prev_reg; // Previous selected source
            logic [2:0] evt_reg; // Capture divider counter
            logic pulse_reg; // Registered capture strobe
            logic src; // Selected capture source
            logic edge_seen; // Rising edge on the source
            logic [2:0] evt_last; // Event count that fires a capture

            // Compare fields only mean something in output mode
            assign oc_config[c] = is_in ? '0 : tcmc_oc_t'{
                clear_on_ext: cfg[TCMC_CLR_BIT],
                compare_behaviour: cfg[TCMC_MODE_LSB +: 3],
                shadow_on: cfg[TCMC_PRE_BIT],
                quick_response: cfg[TCMC_FAST_BIT]};
            assign channel_is_input[c] = is_in;
            assign capture_pulse[c] = pulse_reg;
            assign filtered_level[c] = lvl_reg;

            // Own input, pair neighbour, or trigger
            assign src = (sel == TCMC_SEL_OWN) ? lvl_reg :
                         (sel == TCMC_SEL_NBR) ?
                             filtered_level[c ^ 1] :
                         (sel == TCMC_SEL_TRG) ?
                             internal_trigger_source & trg_ok :
                         1'b0;
            // Previous source resets to 0, its idle level: no false edge
            assign edge_seen = is_in & src & ~src_prev_reg;
            // 1, 2, 4 or 8 events per capture
            assign evt_last = 3'((4'h1 << psc) - 4'h1);

            // Filter: flip only after N matching samples
            // A sample equal to the level restarts the count, so only
            // an unbroken run of N new-level samples moves the output.
            always_ff @(posedge core_clk) begin
                if (!resetn) begin
                    run_reg <= '0;
                    lvl_reg <= 1'b0;
                end else if (flt.bypass) begin
                    run_reg <= '0;
                    lvl_reg <= sync_reg[c];
                end else if (tick[flt.rate]) begin
                    if (sync_reg[c] == lvl_reg) begin
                        run_reg <= '0; // Glitch restarts the count
                    end else if ({1'b0, run_reg} == flt.events - 4'h1) begin
                        run_reg <= '0;
                        lvl_reg <= sync_reg[c];
                    end else begin
                        run_reg <= run_reg + 3'h1;
                    end
                end
            end

            // Capture divider and strobe
            // Only rising edges count; polarity lives elsewhere.
            // Clearing the counter while disabled means every restart
            // begins a fresh divide sequence.
            always_ff @(posedge core_clk) begin
                if (!resetn) begin
                    src_prev_reg <= 1'b0;
                    evt_reg <= '0;
                    pulse_reg <= 1'b0;
                end else begin
                    src_prev_reg <= src;
                    pulse_reg <= 1'b0;
                    if (!ena_reg[c]) begin
                        evt_reg <= '0;
                    end else if (edge_seen) begin
                        if (evt_reg >= evt_last) begin
                            evt_reg <= '0;
                            pulse_reg <= 1'b1;
                        end else begin
                            evt_reg <= evt_reg + 3'h1;
                        end
                    end
                end
            end
        end
    endgenerate

endmodule : tcmc_timer_channel

// File: tcmc_timer_channel_asserts.sv
module tcmc_timer_channel_asserts
    import tcmc_pkg::*;
#(
    parameter int NCH = 4
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [NCH-1:0] timer_input,
    input wire logic internal_trigger_source,
    input wire tcmc_oc_t [NCH-1:0] oc_config,
    input wire logic [NCH-1:0] channel_is_input,
    input wire logic [NCH-1:0] capture_pulse,
    input wire logic [NCH-1:0] filtered_level
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ----
    // Shadow of the enables, so locks are known
    // ----
    logic [15:0] ena_reg;
    logic oc_leak; // Compare bits seen on an input channel
    wire acc_w = avs_write && !avs_waitrequest;
    wire w12 = acc_w && avs_address == TCMC_OFS_CH12 && avs_byteenable[0];
    wire w34 = acc_w && avs_address == TCMC_OFS_CH34;
    // Update only on accepted writes
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ena_reg <= 16'h0000;
        end else if (acc_w && avs_address == TCMC_OFS_ENA) begin
            ena_reg <= avs_writedata[15:0];
        end
    end
    // Any input channel leaking compare controls
    always_comb begin
        oc_leak = 1'b0;
        for (int c = 0; c < NCH; c++) begin
            if (channel_is_input[c] && oc_config[c] != 6'h00) begin
                oc_leak = 1'b1;
            end
        end
    end
    property p_ch3_sel;
        w34 && avs_byteenable[0] && !ena_reg[8] |=>
            channel_is_input[2] == ($past(avs_writedata[1:0]) != 2'h0);
    endproperty
    a_ch3_sel: assert property (p_ch3_sel)
        else $error("ch3 direction not taken");
    property p_ch3_lock;
        w34 && avs_byteenable[0] && ena_reg[8] |=>
            $stable(channel_is_input[2]);
    endproperty
    a_ch3_lock: assert property (p_ch3_lock)
        else $error("ch3 select changed while enabled");
    property p_ch4_oc;
        w34 && avs_byteenable[1] && !ena_reg[12] && avs_writedata[9:8] == 2'h0
            |=> oc_config[3] == $past(avs_writedata[15:10]);
    endproperty
    a_ch4_oc: assert property (p_ch4_oc)
        else $error("ch4 compare fields misplaced");
    property p_ch3_oc;
        w34 && avs_byteenable[0] && !ena_reg[8] && avs_writedata[1:0] == 2'h0
            |=> oc_config[2] == $past(avs_writedata[7:2]);
    endproperty
    a_ch3_oc: assert property (p_ch3_oc)
        else $error("ch3 compare fields misplaced");
    property p_ch1_sel;
        w12 && !ena_reg[0] |=>
            channel_is_input[0] == ($past(avs_writedata[1:0]) != 2'h0);
    endproperty
    a_ch1_sel: assert property (p_ch1_sel)
        else $error("ch1 direction not taken");
    property p_oc_zero;
        !oc_leak;
    endproperty
    a_oc_zero: assert property (p_oc_zero)
        else $error("compare controls shown in input mode");
    property p_pulse_dir;
        (capture_pulse & ~channel_is_input) == '0;
    endproperty
    a_pulse_dir: assert property (p_pulse_dir)
        else $error("capture on an output channel");
    property p_pulse_one;
        (capture_pulse & $past(capture_pulse)) == '0;
    endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("capture pulse longer than one cycle");
endmodule : tcmc_timer_channel_asserts

bind tcmc_timer_channel tcmc_timer_channel_asserts #(.NCH(NCH)) u_chk (
    .core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer_input(timer_input),
    .internal_trigger_source(internal_trigger_source),
    .oc_config(oc_config), .channel_is_input(channel_is_input),
    .capture_pulse(capture_pulse), .filtered_level(filtered_level)
);

// File: tb_top.sv
module tb_top
    import tcmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [3:0] timer_input = 4'h0;
    logic internal_trigger_source = 1'b0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    tcmc_oc_t [3:0] oc_config;
    logic [3:0] channel_is_input, capture_pulse, filtered_level;
    int fails = 0, compares = 0, cyc = 0;
    logic [15:0] lf = 16'h001d; // Random source, seeded
    logic [31:0] rq[$]; // Expected read data
    logic [3:0] pq[$]; // Expected capture pulses
    logic [3:0] fc[9] = '{4'h1, 4'h2, 4'h4, 4'h7, 4'h9, 4'hc, 4'hf,
                          4'h8, 4'h0};
    int gl[9] = '{1, 3, 8, 20, 40, 90, 100, 32, 1}; // Short, bar bypass
    int lg[9] = '{8, 10, 20, 40, 80, 160, 300, 80, 8}; // Long enough
    tcmc_timer_channel dut (
        .core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .timer_input(timer_input),
        .internal_trigger_source(internal_trigger_source),
        .oc_config(oc_config), .channel_is_input(channel_is_input),
        .capture_pulse(capture_pulse), .filtered_level(filtered_level)
    );
    always #5 core_clk = ~core_clk;
    // ----
    // Helpers
    // ----
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: exp %h got %h", $time, e, g);
        end
    endtask : chk
    task automatic complete_run;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input bit wr, input logic [7:0] a,
                       input logic [15:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_read <= !wr;
        avs_write <= wr;
        // Only the bench's cycle ceiling ends a hung wait
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        rq.push_back({16'h0000, e});
        bus(0, a, 16'h0000);
    endtask : rd
    // Raise pin 0 or the trigger for hi cycles, then rest lo cycles
    task automatic src(input bit t, input int hi, input int lo);
        @(posedge core_clk);
        if (t) internal_trigger_source <= 1'b1;
        else timer_input[0] <= 1'b1;
        repeat (hi) @(posedge core_clk);
        internal_trigger_source <= 1'b0;
        timer_input[0] <= 1'b0;
        repeat (lo) @(posedge core_clk);
    endtask : src
    // Watcher: read data and capture pulses against the notes
    always @(posedge core_clk) begin
        if (resetn && avs_read && avs_waitrequest === 1'b0) begin
            chk(rq.pop_front(), avs_readdata);
        end
        if (resetn && capture_pulse !== 4'h0) begin
            chk({28'h0, pq.size() ? pq.pop_front() : 4'h0},
                {28'h0, capture_pulse});
        end
    end
    // Hang guard, well above the expected run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        for (int a = 'h18; a <= 'h2c; a += 4) rd(a[7:0], 16'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            lf = lfsr_next(lf);
            bus(1, i[0] ? TCMC_OFS_CH34 : TCMC_OFS_CH12, lf);
            rd(i[0] ? TCMC_OFS_CH34 : TCMC_OFS_CH12, lf);
        end
        bus(1, TCMC_OFS_CH12, 16'h1234);
        avs_byteenable <= 4'h2;
        bus(1, TCMC_OFS_CH12, 16'hffff);
        avs_byteenable <= 4'hf;
        rd(TCMC_OFS_CH12, 16'hff34);
        bus(1, TCMC_OFS_CH34, 16'hfcfc);
        bus(1, TCMC_OFS_ENA, 16'h1111);
        bus(1, TCMC_OFS_CH34, 16'h0303);
        rd(TCMC_OFS_CH34, 16'h0000);
        bus(1, TCMC_OFS_ENA, 16'h0000);
        $display("test registers done");
        for (int p = 0; p < 4; p++) begin
            bus(1, TCMC_OFS_CH12, {8'h00, 4'h1, p[1:0], 2'h1});
            bus(1, TCMC_OFS_ENA, 16'h0001);
            repeat (8 >> p) pq.push_back(4'h1);
            repeat (8) src(0, 6, 6);
            bus(1, TCMC_OFS_ENA, 16'h0000);
        end
        bus(1, TCMC_OFS_ENA, 16'h0001);
        repeat (4) src(0, 6, 6);
        bus(1, TCMC_OFS_ENA, 16'h0000);
        bus(1, TCMC_OFS_ENA, 16'h0001);
        repeat (4) src(0, 6, 6);
        bus(1, TCMC_OFS_ENA, 16'h0000);
        $display("test divider done");
        for (int i = 0; i < 9; i++) begin
            bus(1, TCMC_OFS_CH12, {8'h00, fc[i], 4'h1});
            bus(1, TCMC_OFS_ENA, 16'h0001);
            // Bypass lets even a one cycle pulse through
            if (fc[i] == 4'h0) pq.push_back(4'h1);
            src(0, gl[i], lg[i]);
            pq.push_back(4'h1);
            src(0, lg[i], lg[i]);
            bus(1, TCMC_OFS_ENA, 16'h0000);
        end
        $display("test filter done");
        bus(1, TCMC_OFS_TRG, 16'h0004);
        bus(1, TCMC_OFS_CH12, 16'h0013);
        bus(1, TCMC_OFS_ENA, 16'h0001);
        src(1, 8, 8);
        bus(1, TCMC_OFS_TRG, 16'h0000);
        pq.push_back(4'h1);
        src(1, 8, 8);
        bus(1, TCMC_OFS_ENA, 16'h0000);
        bus(1, TCMC_OFS_CH12, 16'h1200);
        bus(1, TCMC_OFS_ENA, 16'h0010);
        pq.push_back(4'h2);
        src(0, 8, 8);
        // Pin held high: status shows ch2 as input and pin 0 level
        @(posedge core_clk);
        timer_input[0] <= 1'b1;
        pq.push_back(4'h2);
        repeat (6) @(posedge core_clk);
        rd(TCMC_OFS_STAT, 16'h0021);
        timer_input[0] <= 1'b0;
        bus(1, TCMC_OFS_ENA, 16'h0000);
        repeat (20) @(posedge core_clk);
        chk(32'h0, pq.size());
        $display("test sources done");
        complete_run();
    end
endmodule : tb_top
